// ### common/ccd_defines.vh
/*
  Constants for the clear, call and decrement executor: opcode patterns,
  field positions, widths and the status page-bit positions.
  Assumes 12-bit instruction words and an 8-bit data path.
*/
`ifndef CCD_DEFINES_VH
`define CCD_DEFINES_VH

`define CCD_IW 12
`define CCD_DW 8
`define CCD_AW 5
`define CCD_PCW 11

// Opcode patterns, compared under the matching mask
`define CCD_OP_CLR_WORK 12'h040
`define CCD_MSK_FULL 12'hFFF
`define CCD_OP_KICK 12'h004
`define CCD_OP_CLR_FILE 12'h060
`define CCD_MSK_CLR_FILE 12'hFE0
`define CCD_OP_INV 12'h240
`define CCD_OP_DEC 12'h0C0
`define CCD_OP_DSZ 12'h2C0
`define CCD_MSK_FD 12'hFC0
`define CCD_OP_CALL 12'h900
`define CCD_MSK_CALL 12'hF00
`define CCD_OP_BTC 12'h600
`define CCD_OP_BTS 12'h700
`define CCD_MSK_BT 12'hF00

// Field positions
`define CCD_F_ADDR 4:0
`define CCD_F_DEST 5
`define CCD_F_BIT 7:5
`define CCD_F_LIT 7:0
`define CCD_ST_PAGE 6:5

// Operation selects for the result unit
`define CCD_ALU_ZERO 2'h0
`define CCD_ALU_INV 2'h1
`define CCD_ALU_DEC 2'h2

`define CCD_B0 1'h0
`define CCD_B1 1'h1
`define CCD_ZERO8 8'h00
`define CCD_PC_ONE 11'h001

`endif

// ### rtl/ccd_alu.v
/*
  Result unit: zero, complement or decrement of an 8-bit operand,
  with the zero indication of the result.
  Purely combinational; the caller registers what it needs.
*/
`timescale 1ns/1ps
`include "ccd_defines.vh"

module ccd_alu (
  input wire [1:0] op_sel, // Operation select
  input wire [`CCD_DW-1:0] operand, // File register value
  output reg [`CCD_DW-1:0] result, // Operation result
  output wire result_zero // Result equals zero
);

  always @*
  begin
    case (op_sel)
      `CCD_ALU_INV: result = ~operand;
      // Eight-bit subtract drops the borrow, so 00h wraps to FFh
      `CCD_ALU_DEC: result = operand - `CCD_B1;
      default: result = `CCD_ZERO8;
    endcase
  end

  assign result_zero = (result == `CCD_ZERO8);

endmodule

// ### rtl/ccd_core.v
/*
  Executor for clear, call, watchdog kick, complement, decrement and
  decrement-with-skip, plus the discard slot of bit-test skips.
  Assumes one fetched instruction per cycle on instr/instr_valid, a file
  register read port answering combinationally on file_rd_addr, and that
  the register file, status register, stack and watchdog apply the
  one-cycle strobes driven here.
*/
`timescale 1ns/1ps
`include "ccd_defines.vh"

module ccd_core (
  input wire clk, // 50 MHz core clock
  input wire srst, // Synchronous reset, active high
  input wire instr_valid, // Fetched instruction present
  input wire [`CCD_IW-1:0] instr, // Fetched instruction word
  input wire [`CCD_PCW-1:0] pc_in, // Address of the executing instruction
  input wire [`CCD_DW-1:0] status_in, // Current status register
  input wire prescaler_to_wdt, // Prescaler assigned to watchdog
  output wire [`CCD_AW-1:0] file_rd_addr, // File register read address
  input wire [`CCD_DW-1:0] file_rd_data, // File register read data
  output reg [`CCD_DW-1:0] w_q, // Working register
  output reg file_we_q, // File register write strobe
  output reg [`CCD_AW-1:0] file_wa_q, // File register write address
  output reg [`CCD_DW-1:0] file_wd_q, // File register write data
  output reg zero_we_q, // Zero flag write strobe
  output reg zero_val_q, // Zero flag value
  output reg flags_set_q, // Set timeout_flag_n and powerdown_flag_n
  output reg wdt_clr_q, // Clear watchdog_counter
  output reg presc_clr_q, // Clear prescaler
  output reg push_q, // Return stack push strobe
  output reg [`CCD_PCW-1:0] push_addr_q, // Return address pushed
  output reg pc_load_q, // Load program_counter
  output reg [`CCD_PCW-1:0] pc_target_q, // New program_counter value
  output reg discard_q // Current slot executes as a no-operation
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  wire live;
  wire is_clear_working;
  wire is_kick;
  wire is_clear_file;
  wire is_inv;
  wire is_dec;
  wire is_dsz;
  wire is_call;
  wire is_btc;
  wire is_bts;
  wire dest_file;
  wire [`CCD_AW-1:0] faddr;
  wire [`CCD_DW-1:0] alu_res;
  wire alu_zero;
  wire tested_bit;
  reg [1:0] alu_sel;
  reg skip_d;

  // A discarded slot behaves as a no-operation whatever was fetched
  assign live = instr_valid & ~discard_q;
  assign is_clear_working = live & ((instr & `CCD_MSK_FULL) == `CCD_OP_CLR_WORK);
  assign is_kick = live & ((instr & `CCD_MSK_FULL) == `CCD_OP_KICK);
  assign is_clear_file = live & ((instr & `CCD_MSK_CLR_FILE) == `CCD_OP_CLR_FILE);
  assign is_inv = live & ((instr & `CCD_MSK_FD) == `CCD_OP_INV);
  assign is_dec = live & ((instr & `CCD_MSK_FD) == `CCD_OP_DEC);
  assign is_dsz = live & ((instr & `CCD_MSK_FD) == `CCD_OP_DSZ);
  assign is_call = live & ((instr & `CCD_MSK_CALL) == `CCD_OP_CALL);
  assign is_btc = live & ((instr & `CCD_MSK_BT) == `CCD_OP_BTC);
  assign is_bts = live & ((instr & `CCD_MSK_BT) == `CCD_OP_BTS);
  assign dest_file = instr[`CCD_F_DEST];
  assign faddr = instr[`CCD_F_ADDR];
  assign file_rd_addr = faddr;
  assign tested_bit = file_rd_data[instr[`CCD_F_BIT]];

  always @*
  begin
    if (is_inv)
      alu_sel = `CCD_ALU_INV;
    else if (is_dec | is_dsz)
      alu_sel = `CCD_ALU_DEC;
    else
      alu_sel = `CCD_ALU_ZERO;
  end

  ccd_alu u_alu (
    .op_sel(alu_sel),
    .operand(file_rd_data),
    .result(alu_res),
    .result_zero(alu_zero)
  );

  // Skip decisions; a call also needs its prefetched successor dropped
  always @*
  begin
    skip_d = `CCD_B0;
    if (is_dsz & alu_zero)
      skip_d = `CCD_B1;
    else if (is_btc & ~tested_bit)
      skip_d = `CCD_B1;
    else if (is_bts & tested_bit)
      skip_d = `CCD_B1;
    else if (is_call)
      skip_d = `CCD_B1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Working register

  always @(posedge clk)
  begin
    if (srst)
      w_q <= `CCD_ZERO8;
    else if (is_clear_working)
      w_q <= `CCD_ZERO8;
    else if ((is_inv | is_dec | is_dsz) & ~dest_file)
      w_q <= alu_res;
  end

  ////////////////////////////////////////////////////////////////////////////
  // File register write port

  always @(posedge clk)
  begin
    if (srst)
    begin
      file_we_q <= `CCD_B0;
      file_wa_q <= {`CCD_AW{`CCD_B0}};
      file_wd_q <= `CCD_ZERO8;
    end
    else
    begin
      file_we_q <= `CCD_B0;
      file_wa_q <= faddr;
      if (is_clear_file)
      begin
        file_we_q <= `CCD_B1;
        file_wd_q <= `CCD_ZERO8;
      end
      else if ((is_inv | is_dec | is_dsz) & dest_file)
      begin
        file_we_q <= `CCD_B1;
        file_wd_q <= alu_res;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Zero flag

  always @(posedge clk)
  begin
    if (srst)
    begin
      zero_we_q <= `CCD_B0;
      zero_val_q <= `CCD_B0;
    end
    else
    begin
      zero_we_q <= `CCD_B0;
      // Decrement-and-skip never raises the zero strobe
      if (is_clear_working | is_clear_file)
      begin
        zero_we_q <= `CCD_B1;
        zero_val_q <= `CCD_B1;
      end
      else if (is_inv | is_dec)
      begin
        zero_we_q <= `CCD_B1;
        zero_val_q <= alu_zero;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog kick

  always @(posedge clk)
  begin
    if (srst)
    begin
      wdt_clr_q <= `CCD_B0;
      presc_clr_q <= `CCD_B0;
      flags_set_q <= `CCD_B0;
    end
    else
    begin
      wdt_clr_q <= is_kick;
      presc_clr_q <= is_kick & prescaler_to_wdt;
      flags_set_q <= is_kick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Call

  always @(posedge clk)
  begin
    if (srst)
    begin
      push_q <= `CCD_B0;
      push_addr_q <= {`CCD_PCW{`CCD_B0}};
      pc_load_q <= `CCD_B0;
      pc_target_q <= {`CCD_PCW{`CCD_B0}};
    end
    else
    begin
      push_q <= is_call;
      pc_load_q <= is_call;
      if (is_call)
      begin
        push_addr_q <= pc_in + `CCD_PC_ONE;
        // Bit 8 forced low: call targets sit in the lower half-page
        pc_target_q <= {status_in[`CCD_ST_PAGE], `CCD_B0, instr[`CCD_F_LIT]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Discard slot

  always @(posedge clk)
  begin
    if (srst)
      discard_q <= `CCD_B0;
    else
      discard_q <= skip_d;
  end

endmodule

// ### test/ccd_monitor.sv
/* Assertion checker for the executor: results, strobes and skips.
   Sees only ccd_core ports; bound from the testbench top. */
`timescale 1ns/1ps
module ccd_monitor (
  input wire clk, // Clock
  input wire srst, // Reset
  input wire instr_valid, // Valid
  input wire [11:0] instr, // Word
  input wire [10:0] pc_in, // Counter
  input wire [7:0] status_in, // Status
  input wire prescaler_to_wdt, // Assignment
  input wire [7:0] file_rd_data, // Operand
  input wire [7:0] w_q, // Working
  input wire file_we_q, // Write
  input wire [7:0] file_wd_q, // Write data
  input wire zero_we_q, // Zero write
  input wire zero_val_q, // Zero value
  input wire flags_set_q, // Flags
  input wire wdt_clr_q, // Kick
  input wire presc_clr_q, // Prescaler
  input wire push_q, // Push
  input wire [10:0] push_addr_q, // Return
  input wire pc_load_q, // Load
  input wire [10:0] pc_target_q, // Target
  input wire discard_q // Slot
);
  // A word sitting in a discard slot is never taken
  wire tk = instr_valid & ~discard_q;
  wire call = tk & (instr[11:8] == 4'h9);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////
  a_clear_working: assert property (tk && instr == 12'h040 |=> w_q == 8'h00 && zero_we_q && zero_val_q)
    else $error("clear working wrong");
  a_call_load: assert property (call |=> push_q && pc_load_q && push_addr_q == $past(pc_in) + 11'h001
    && pc_target_q == {$past(status_in[6:5]), 1'h0, $past(instr[7:0])}) else $error("call load wrong");
  a_call_slot: assert property (call |=> discard_q && !zero_we_q && !flags_set_q ##1 !push_q)
    else $error("call slot wrong");
  a_kick_clears: assert property (tk && instr == 12'h004 |=> wdt_clr_q && flags_set_q
    && presc_clr_q == $past(prescaler_to_wdt)) else $error("kick wrong");
  a_clear_file: assert property (tk && instr[11:5] == 7'h03 |=> file_we_q && file_wd_q == 8'h00 && zero_val_q)
    else $error("clear file wrong");
  a_dec_dest: assert property (tk && instr[11:6] == 6'h03 |=> file_we_q == $past(instr[5])
    && zero_we_q && zero_val_q == ($past(file_rd_data) == 8'h01)
    && (file_we_q ? file_wd_q : w_q) == $past(file_rd_data) - 8'h01) else $error("decrement wrong");
  a_dec_skip: assert property (tk && instr[11:6] == 6'h0B |=> !zero_we_q
    && discard_q == ($past(file_rd_data) == 8'h01)) else $error("decrement skip wrong");
  a_bit_skip: assert property (tk && instr[11:9] == 3'h3 |=> discard_q == $past(file_rd_data[instr[7:5]] == instr[8]))
    else $error("bit skip wrong");
  a_invert_result: assert property (tk && instr[11:6] == 6'h09 |=> file_we_q == $past(instr[5])
    && zero_we_q && zero_val_q == ($past(file_rd_data) == 8'hFF)
    && (file_we_q ? file_wd_q : w_q) == ~$past(file_rd_data)) else $error("invert wrong");
  a_dest_only: assert property (tk && (instr[11:6] == 6'h03 || instr[11:6] == 6'h09 || instr[11:6] == 6'h0B)
    |=> ($past(instr[5]) ? $stable(w_q) : !file_we_q)) else $error("result left its destination");
endmodule

// ### test/tb_ccd_core.sv
/* Testbench for ccd_core: instruction sequences with expected results.
   Assumes ccd_defines.vh on the include path and ccd_monitor compiled first. */
`timescale 1ns/1ps
module tb_ccd_core;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic instr_valid = 1'h0;
  logic prescaler_to_wdt = 1'h0;
  logic [11:0] instr = 12'h000;
  logic [10:0] pc_in = 11'h000;
  logic [7:0] status_in = 8'h00;
  logic [7:0] file_rd_data = 8'h00;
  wire [4:0] file_rd_addr, file_wa_q;
  wire [7:0] w_q, file_wd_q;
  wire [10:0] push_addr_q, pc_target_q;
  wire file_we_q, zero_we_q, zero_val_q, flags_set_q, wdt_clr_q, presc_clr_q, push_q, pc_load_q, discard_q;
  int fail_count = 0;
  int checks = 0;
  ccd_core u_ccd_core (
    .clk(clk), // Clock
    .srst(srst), // Reset
    .instr_valid(instr_valid), // Valid
    .instr(instr), // Word
    .pc_in(pc_in), // Counter
    .status_in(status_in), // Status
    .prescaler_to_wdt(prescaler_to_wdt), // Assignment
    .file_rd_addr(file_rd_addr), // Read address
    .file_rd_data(file_rd_data), // Operand
    .w_q(w_q), // Working
    .file_we_q(file_we_q), // Write
    .file_wa_q(file_wa_q), // Write address
    .file_wd_q(file_wd_q), // Write data
    .zero_we_q(zero_we_q), // Zero write
    .zero_val_q(zero_val_q), // Zero value
    .flags_set_q(flags_set_q), // Flags
    .wdt_clr_q(wdt_clr_q), // Kick
    .presc_clr_q(presc_clr_q), // Prescaler
    .push_q(push_q), // Push
    .push_addr_q(push_addr_q), // Return
    .pc_load_q(pc_load_q), // Load
    .pc_target_q(pc_target_q), // Target
    .discard_q(discard_q) // Slot
  );
  ////////////////////////////////////////
  task chk(input logic [10:0] seen, input logic [10:0] exp, input string nm);
    begin
      checks++;
      if (seen !== exp)
      begin
        fail_count++;
        $display("Error %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // Present one word at a falling edge; outputs are settled one edge later
  task run(input logic [11:0] i, input logic [7:0] f);
    begin
      instr = i;
      file_rd_data = f;
      @(negedge clk);
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial
  begin
    forever #10 clk = ~clk;
  end
  initial
  begin
    #200000;
    fail_count++;
    wrap_up;
  end
  initial
  begin
    repeat (16) @(negedge clk);
    srst = 1'h0;
    chk(w_q, 11'h000, "w_q");
    instr_valid = 1'h1;
    run(12'h242, 8'h00);
    chk(w_q, 11'h0FF, "w_q");
    chk(file_we_q, 11'h000, "file_we_q");
    chk(zero_val_q, 11'h000, "zero_val_q");
    run(12'h040, 8'h55);
    chk(w_q, 11'h000, "w_q");
    chk(zero_val_q, 11'h001, "zero_val_q");
    run(12'h0E4, 8'h00);
    chk(file_wd_q, 11'h0FF, "file_wd_q");
    chk(file_wa_q, 11'h004, "file_wa_q");
    chk(file_we_q, 11'h001, "file_we_q");
    chk(w_q, 11'h000, "w_q");
    run(12'h0C4, 8'h01);
    chk(zero_val_q, 11'h001, "zero_val_q");
    run(12'h2E3, 8'h01);
    chk(zero_we_q, 11'h000, "zero_we_q");
    chk(discard_q, 11'h001, "discard_q");
    run(12'h040, 8'h00);
    chk(zero_we_q, 11'h000, "zero_we_q");
    run(12'h2C5, 8'h05);
    chk(w_q, 11'h004, "w_q");
    chk(discard_q, 11'h000, "discard_q");
    run(12'h262, 8'hFF);
    chk(file_wd_q, 11'h000, "file_wd_q");
    chk(file_we_q, 11'h001, "file_we_q");
    chk(zero_val_q, 11'h001, "zero_val_q");
    chk(w_q, 11'h004, "w_q");
    pc_in = 11'h005;
    status_in = 8'h60;
    run(12'h912, 8'h00);
    chk(push_addr_q, 11'h006, "push_addr_q");
    chk(pc_target_q, 11'h612, "pc_target_q");
    chk(discard_q, 11'h001, "discard_q");
    run(12'h000, 8'h00);
    pc_in = 11'h7FF;
    status_in = 8'h40;
    run(12'h9FF, 8'h00);
    chk(push_addr_q, 11'h000, "push_addr_q");
    chk(pc_target_q, 11'h4FF, "pc_target_q");
    chk(pc_load_q, 11'h001, "pc_load_q");
    run(12'h000, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      prescaler_to_wdt = k[0];
      run(12'h004, 8'h00);
      chk(wdt_clr_q, 11'h001, "wdt_clr_q");
      chk(presc_clr_q, k[0], "presc_clr_q");
      chk(flags_set_q, 11'h001, "flags_set_q");
    end
    run(12'h07F, 8'hAA);
    chk(file_wa_q, 11'h01F, "file_wa_q");
    chk(file_wd_q, 11'h000, "file_wd_q");
    chk(file_rd_addr, 11'h01F, "file_rd_addr");
    for (int k = 0; k < 3; k++)
    begin
      run(k == 1 ? 12'h763 : 12'h663, k == 0 ? 8'h00 : 8'h08);
      chk(discard_q, k < 2, "discard_q");
      run(12'h000, 8'h00);
    end
    instr_valid = 1'h0;
    @(negedge clk);
    wrap_up;
  end
endmodule
bind ccd_core ccd_monitor u_ccd_monitor (
  .clk(clk), .srst(srst), .instr_valid(instr_valid), .instr(instr), .pc_in(pc_in),
  .status_in(status_in), .prescaler_to_wdt(prescaler_to_wdt), .file_rd_data(file_rd_data),
  .w_q(w_q), .file_we_q(file_we_q), .file_wd_q(file_wd_q), .zero_we_q(zero_we_q),
  .zero_val_q(zero_val_q), .flags_set_q(flags_set_q), .wdt_clr_q(wdt_clr_q),
  .presc_clr_q(presc_clr_q), .push_q(push_q), .push_addr_q(push_addr_q),
  .pc_load_q(pc_load_q), .pc_target_q(pc_target_q), .discard_q(discard_q)
);
